// file: common/opc_pkg.sv
/*
  Constants, register layout and carrier types for the output path control bank:
  line output stage enables, output source selects, and the paired volume update
  with zero-cross gating and timeout.
  Assumes a single control clock; registers sit at four times their index on AHB-Lite.
*/
// Functional notes
// - Bit 4 enables left line input stage.
// - Bit 5 enables left line middle stage.
// - Bit 6 enables left line output stage.
// - Bit 7 releases left line short; reset shorted.
// - Bits 3..0 same controls for right line.
// - Bit 3 selects left phones source.
// - Bit 2 selects right phones source.
// - Bits 1,0 select left/right line source.
// - After reset every output fed by DAC.
// - Each output has independent volume, mute.
// - Zero-cross holds volume change until crossing.
// - Timeout applies pending change when enabled.
// - Write without update bit leaves gain unchanged; the bank loads a newly written gain if a change is pending.
// - Update bit applies both pair gains together; with zero-cross on, each output here applies at its own crossing or timeout.
// - Six-bit gain field, 1 dB steps.
// - Bit 8 mutes the output.
// - Bit 6 enables zero-cross gating.

package opc_pkg;

  // ==========================================================================
  // Register indices; byte address is four times the index.
  // ==========================================================================
  localparam int unsigned OPC_IDX_W = 7;
  typedef logic [OPC_IDX_W-1:0] opc_idx_type;

  localparam opc_idx_type OPC_IDX_PHONES_LEFT_VOL = 7'h39;
  localparam opc_idx_type OPC_IDX_PHONES_RIGHT_VOL = 7'h3A;
  localparam opc_idx_type OPC_IDX_LINE_LEFT_VOL = 7'h3B;
  localparam opc_idx_type OPC_IDX_LINE_RIGHT_VOL = 7'h3C;
  localparam opc_idx_type OPC_IDX_OUTPUT_MUX_SELECT = 7'h3D;
  localparam opc_idx_type OPC_IDX_LINE_OUTPUT_POP_CONTROL = 7'h5E;
  localparam opc_idx_type OPC_IDX_TIMEOUT_CONTROL = 7'h70;
  localparam opc_idx_type OPC_IDX_APPLIED_GAIN = 7'h71;
  localparam opc_idx_type OPC_IDX_PENDING_STATUS = 7'h72;

  // ==========================================================================
  // Field positions and widths
  // ==========================================================================
  localparam int unsigned OPC_GAIN_W = 6;
  localparam int unsigned OPC_VOL_MUTE_BIT = 8;
  localparam int unsigned OPC_VOL_UPDATE_BIT = 7;
  localparam int unsigned OPC_VOL_ZC_BIT = 6;
  localparam int unsigned OPC_TIMEOUT_CLOCK_ON_BIT = 0;
  localparam int unsigned OPC_CHANNELS = 4;

  // Channel order on every vector: phones left, phones right, line left, line right.
  localparam int unsigned OPC_CH_PHONES_LEFT = 0;
  localparam int unsigned OPC_CH_PHONES_RIGHT = 1;
  localparam int unsigned OPC_CH_LINE_LEFT = 2;
  localparam int unsigned OPC_CH_LINE_RIGHT = 3;

  // ==========================================================================
  // Bus encodings and counts
  // ==========================================================================
  localparam logic [1:0] OPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] OPC_HSIZE_WORD = 3'h2;
  localparam logic OPC_HRESP_OKAY = 1'b0;
  localparam int unsigned OPC_TIMEOUT_TICKS_DEFAULT = 16;
  localparam int unsigned OPC_TIMEOUT_CNT_W_DEFAULT = 8;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef logic [OPC_GAIN_W-1:0] opc_gain_type;
  typedef opc_gain_type [OPC_CHANNELS-1:0] opc_gain_vec_type;

  typedef struct packed {
    logic left_line_short_release;
    logic left_line_output_stage_on;
    logic left_line_middle_stage_on;
    logic left_line_input_stage_on;
    logic right_line_short_release;
    logic right_line_output_stage_on;
    logic right_line_middle_stage_on;
    logic right_line_input_stage_on;
  } opc_line_ctrl_type;

  typedef struct packed {
    logic left_phones_bypass_select;
    logic right_phones_bypass_select;
    logic left_line_bypass_select;
    logic right_line_bypass_select;
  } opc_mux_type;

  typedef struct packed {
    logic silence;
    logic zero_cross_on;
    opc_gain_type gain;
  } opc_vol_type;

  typedef opc_vol_type [OPC_CHANNELS-1:0] opc_vol_vec_type;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam opc_line_ctrl_type OPC_LINE_CTRL_RST = 8'h00;
  localparam opc_mux_type OPC_MUX_RST = 4'h0;
  localparam opc_gain_type OPC_PHONES_GAIN_RST = 6'h2D;
  localparam opc_gain_type OPC_LINE_GAIN_RST = 6'h39;
  localparam opc_vol_type OPC_PHONES_VOL_RST = {1'b0, 1'b0, OPC_PHONES_GAIN_RST};
  localparam opc_vol_type OPC_LINE_VOL_RST = {1'b0, 1'b0, OPC_LINE_GAIN_RST};

endpackage : opc_pkg

// file: core/opc_vol_channel.sv
/*
  One output's volume latch: holds the applied gain, waits for a zero crossing
  or a timeout when gating is on, and loads the stored gain when allowed.
  Assumes update, tick and samples are single-cycle pulses on the same clock.
*/
`timescale 1ns/100ps

module opc_vol_channel #(
  parameter int unsigned TIMEOUT_TICKS = opc_pkg::OPC_TIMEOUT_TICKS_DEFAULT,
  parameter int unsigned CNT_W = opc_pkg::OPC_TIMEOUT_CNT_W_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire opc_pkg::opc_gain_type stored_gain,
  input wire logic zero_cross_on,
  input wire logic update,
  input wire logic sample_valid,
  input wire logic sample_sign,
  input wire logic tick,
  input wire logic timeout_clock_on,
  output opc_pkg::opc_gain_type applied_gain,
  output logic pending
);
  import opc_pkg::*;

  generate
    if (TIMEOUT_TICKS < 1 || TIMEOUT_TICKS >= (2 ** CNT_W)) begin : g_bad_ticks
      $error("opc_vol_channel: TIMEOUT_TICKS does not fit CNT_W");
    end
  endgenerate

  typedef struct packed {
    opc_gain_type applied;
    logic pending;
    logic primed;
    logic last_sign;
    logic [CNT_W-1:0] count;
  } opc_chan_state_type;

  localparam opc_chan_state_type CHAN_RST = '{applied: OPC_PHONES_GAIN_RST, pending: 1'b0, primed: 1'b0,
                                              last_sign: 1'b0, count: '0};

  opc_chan_state_type s;
  opc_chan_state_type next_s;
  logic crossing;
  logic timeout_now;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_s = s;
    crossing = 1'b0;
    timeout_now = 1'b0;
    if (sample_valid) begin
      next_s.last_sign = sample_sign;
      next_s.primed = 1'b1;
      crossing = s.primed && (sample_sign != s.last_sign);
    end
    if (update) begin
      next_s.pending = 1'b1;
      next_s.count = '0;
    end else if (s.pending && tick && timeout_clock_on) begin
      next_s.count = s.count + CNT_W'(1);
      timeout_now = (s.count == CNT_W'(TIMEOUT_TICKS - 1));
    end
    // A gated change waits; turning gating off lets a waiting change through at once.
    if ((update || s.pending) && (!zero_cross_on || crossing || timeout_now)) begin
      next_s.applied = stored_gain;
      next_s.pending = 1'b0;
      next_s.count = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= CHAN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign applied_gain = s.applied;
  assign pending = s.pending;

endmodule : opc_vol_channel

// file: core/opc_output_path_bank.sv
/*
  Output path control bank: AHB-Lite register slave holding line output stage
  enables, output source selects, four volume registers with paired update,
  and the timeout enable; drives the analogue control outputs from flops.
  Assumes one 100 MHz clock, one AHB-Lite master, word transfers only, and a
  timeout tick arriving from another clock domain.
*/
`timescale 1ns/100ps

module opc_output_path_bank #(
  parameter int unsigned TIMEOUT_TICKS = opc_pkg::OPC_TIMEOUT_TICKS_DEFAULT,
  parameter int unsigned CNT_W = opc_pkg::OPC_TIMEOUT_CNT_W_DEFAULT
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic TIMEOUT_TICK,
  input wire logic [3:0] SAMPLE_VALID,
  input wire logic [3:0] SAMPLE_SIGN,
  output opc_pkg::opc_line_ctrl_type LINE_CTRL,
  output opc_pkg::opc_mux_type MUX_SEL,
  output logic [3:0] MUTE,
  output opc_pkg::opc_gain_vec_type GAIN
);
  import opc_pkg::*;

  generate
    if (TIMEOUT_TICKS < 1 || TIMEOUT_TICKS >= (2 ** CNT_W)) begin : g_bad_ticks
      $error("opc_output_path_bank: TIMEOUT_TICKS does not fit CNT_W");
    end
  endgenerate

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    opc_line_ctrl_type line;
    opc_mux_type mux;
    opc_vol_vec_type vol;
    logic [OPC_CHANNELS-1:0] update;
    logic timeout_clock_on;
    logic wr_pend;
    logic rd_wait;
    logic addr_ok;
    opc_idx_type addr_idx;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [2:0] tick_sync;
    logic tick_level;
    logic tick;
  } opc_bank_state_type;

  localparam opc_vol_vec_type VOL_RST = {OPC_LINE_VOL_RST, OPC_LINE_VOL_RST,
                                         OPC_PHONES_VOL_RST, OPC_PHONES_VOL_RST};

  localparam opc_bank_state_type BANK_RST = '{
    line: OPC_LINE_CTRL_RST,
    mux: OPC_MUX_RST,
    vol: VOL_RST,
    update: '0,
    timeout_clock_on: 1'b0,
    wr_pend: 1'b0,
    rd_wait: 1'b0,
    addr_ok: 1'b0,
    addr_idx: '0,
    hreadyout: 1'b1,
    hresp: OPC_HRESP_OKAY,
    hrdata: 32'h00000000,
    tick_sync: 3'h0,
    tick_level: 1'b0,
    tick: 1'b0
  };

  opc_bank_state_type s;
  opc_bank_state_type next_s;
  logic [OPC_CHANNELS-1:0] pending_w;
  opc_gain_vec_type applied_w;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  function automatic logic is_mapped(input opc_idx_type idx);
    logic hit;
    hit = 1'b0;
    unique case (idx)
      OPC_IDX_PHONES_LEFT_VOL,
      OPC_IDX_PHONES_RIGHT_VOL,
      OPC_IDX_LINE_LEFT_VOL,
      OPC_IDX_LINE_RIGHT_VOL,
      OPC_IDX_OUTPUT_MUX_SELECT,
      OPC_IDX_LINE_OUTPUT_POP_CONTROL,
      OPC_IDX_TIMEOUT_CONTROL,
      OPC_IDX_APPLIED_GAIN,
      OPC_IDX_PENDING_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : is_mapped

  function automatic opc_vol_type vol_from_word(input logic [31:0] w);
    opc_vol_type v;
    v.silence = w[OPC_VOL_MUTE_BIT];
    v.zero_cross_on = w[OPC_VOL_ZC_BIT];
    v.gain = w[OPC_GAIN_W-1:0];
    return v;
  endfunction : vol_from_word

  function automatic logic [31:0] word_from_vol(input opc_vol_type v);
    logic [31:0] w;
    w = 32'h00000000;
    w[OPC_VOL_MUTE_BIT] = v.silence;
    w[OPC_VOL_ZC_BIT] = v.zero_cross_on;
    w[OPC_GAIN_W-1:0] = v.gain;
    return w;
  endfunction : word_from_vol

  function automatic int unsigned vol_channel(input opc_idx_type idx);
    int unsigned ch;
    ch = OPC_CH_PHONES_LEFT;
    unique case (idx)
      OPC_IDX_PHONES_RIGHT_VOL: ch = OPC_CH_PHONES_RIGHT;
      OPC_IDX_LINE_LEFT_VOL: ch = OPC_CH_LINE_LEFT;
      OPC_IDX_LINE_RIGHT_VOL: ch = OPC_CH_LINE_RIGHT;
      default: ch = OPC_CH_PHONES_LEFT;
    endcase
    return ch;
  endfunction : vol_channel

  function automatic logic is_vol(input opc_idx_type idx);
    return (idx == OPC_IDX_PHONES_LEFT_VOL) || (idx == OPC_IDX_PHONES_RIGHT_VOL) ||
           (idx == OPC_IDX_LINE_LEFT_VOL) || (idx == OPC_IDX_LINE_RIGHT_VOL);
  endfunction : is_vol

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    int unsigned ch;
    ch = 0;
    next_s = s;
    next_s.update = '0;

    // Timeout tick crossing: only the second and third stages are compared, and
    // a change counts once they agree, so a metastable first stage is never seen.
    next_s.tick_sync = {s.tick_sync[1:0], TIMEOUT_TICK};
    next_s.tick = 1'b0;
    if (s.tick_sync[1] == s.tick_sync[2]) begin
      next_s.tick_level = s.tick_sync[2];
      next_s.tick = s.tick_sync[2] && !s.tick_level;
    end

    // Write data phase of a previously taken address phase.
    if (s.wr_pend) begin
      next_s.wr_pend = 1'b0;
      if (s.addr_ok) begin
        if (s.addr_idx == OPC_IDX_LINE_OUTPUT_POP_CONTROL) begin
          next_s.line = opc_line_ctrl_type'(HWDATA[7:0]);
        end
        if (s.addr_idx == OPC_IDX_OUTPUT_MUX_SELECT) begin
          next_s.mux = opc_mux_type'(HWDATA[3:0]);
        end
        if (s.addr_idx == OPC_IDX_TIMEOUT_CONTROL) begin
          next_s.timeout_clock_on = HWDATA[OPC_TIMEOUT_CLOCK_ON_BIT];
        end
        if (is_vol(s.addr_idx)) begin
          ch = vol_channel(s.addr_idx);
          // Storing alone leaves the applied gain unless the channel has a change pending.
          next_s.vol[ch] = vol_from_word(HWDATA);
          if (HWDATA[OPC_VOL_UPDATE_BIT]) begin
            if (ch == OPC_CH_PHONES_LEFT || ch == OPC_CH_PHONES_RIGHT) begin
              next_s.update[OPC_CH_PHONES_LEFT] = 1'b1;
              next_s.update[OPC_CH_PHONES_RIGHT] = 1'b1;
            end else begin
              next_s.update[OPC_CH_LINE_LEFT] = 1'b1;
              next_s.update[OPC_CH_LINE_RIGHT] = 1'b1;
            end
          end
        end
      end
    end

    // Read wait state: data is formed from settled registers, one cycle late,
    // which costs a wait state; applied gain and pending status read right behind an update write still show the values before it.
    if (s.rd_wait) begin
      next_s.rd_wait = 1'b0;
      next_s.hreadyout = 1'b1;
      next_s.hrdata = 32'h00000000;
      if (s.addr_ok) begin
        unique case (s.addr_idx)
          OPC_IDX_LINE_OUTPUT_POP_CONTROL: next_s.hrdata = {24'h000000, s.line};
          OPC_IDX_OUTPUT_MUX_SELECT: next_s.hrdata = {28'h0000000, s.mux};
          OPC_IDX_TIMEOUT_CONTROL: next_s.hrdata = {31'h00000000, s.timeout_clock_on};
          OPC_IDX_APPLIED_GAIN: next_s.hrdata = {8'h00, applied_w};
          OPC_IDX_PENDING_STATUS: next_s.hrdata = {28'h0000000, pending_w};
          OPC_IDX_PHONES_LEFT_VOL,
          OPC_IDX_PHONES_RIGHT_VOL,
          OPC_IDX_LINE_LEFT_VOL,
          OPC_IDX_LINE_RIGHT_VOL: next_s.hrdata = word_from_vol(s.vol[vol_channel(s.addr_idx)]);
          default: next_s.hrdata = 32'h00000000;
        endcase
      end
    end

    // Address phase. Anything unmapped, unaligned or not a word is taken and
    // answered OKAY, reads as zero and is dropped on write.
    if (HSEL && HREADY && (HTRANS == OPC_HTRANS_NONSEQ)) begin
      next_s.addr_idx = HADDR[OPC_IDX_W+1:2];
      next_s.addr_ok = (HADDR[31:OPC_IDX_W+2] == '0) && (HADDR[1:0] == 2'h0) &&
                       (HSIZE == OPC_HSIZE_WORD) && is_mapped(HADDR[OPC_IDX_W+1:2]);
      if (HWRITE) begin
        next_s.wr_pend = 1'b1;
      end else begin
        next_s.rd_wait = 1'b1;
        next_s.hreadyout = 1'b0;
      end
    end
    next_s.hresp = OPC_HRESP_OKAY;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= BANK_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Per-output volume latches
  // ==========================================================================
  for (genvar g = 0; g < OPC_CHANNELS; g++) begin : g_chan
    opc_vol_channel #(
      .TIMEOUT_TICKS(TIMEOUT_TICKS),
      .CNT_W(CNT_W)
    ) u_chan (
      .clk(CLK),
      .rst_n(RST_N),
      .stored_gain(s.vol[g].gain),
      .zero_cross_on(s.vol[g].zero_cross_on),
      .update(s.update[g]),
      .sample_valid(SAMPLE_VALID[g]),
      .sample_sign(SAMPLE_SIGN[g]),
      .tick(s.tick),
      .timeout_clock_on(s.timeout_clock_on),
      .applied_gain(applied_w[g]),
      .pending(pending_w[g])
    );
  end

  // ==========================================================================
  // Outputs, each straight from a flop
  // ==========================================================================
  assign HRDATA = s.hrdata;
  assign HREADYOUT = s.hreadyout;
  assign HRESP = s.hresp;
  assign LINE_CTRL = s.line;
  assign MUX_SEL = s.mux;
  assign GAIN = applied_w;
  always_comb begin
    for (int i = 0; i < OPC_CHANNELS; i++) begin
      MUTE[i] = s.vol[i].silence;
    end
  end

endmodule : opc_output_path_bank

// file: tb/opc_output_path_bank_props.sv
/*
  Checker for the output path control bank: bus timing and register-to-output relations.
  Assumes one AHB-Lite master with HREADY tied to HREADYOUT.
*/
`timescale 1ns/100ps

module opc_output_path_bank_props #(
  parameter int unsigned TIMEOUT_TICKS = 16,
  parameter int unsigned CNT_W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic TIMEOUT_TICK,
  input wire logic [3:0] SAMPLE_VALID,
  input wire logic [3:0] SAMPLE_SIGN,
  input wire opc_pkg::opc_line_ctrl_type LINE_CTRL,
  input wire opc_pkg::opc_mux_type MUX_SEL,
  input wire logic [3:0] MUTE,
  input wire opc_pkg::opc_gain_vec_type GAIN
);
  import opc_pkg::*;

  // ==========================================================================
  // Helper logic
  // ==========================================================================
  localparam logic [31:0] POP_ADDR = {23'h0, OPC_IDX_LINE_OUTPUT_POP_CONTROL, 2'b00};
  localparam logic [31:0] MUX_ADDR = {23'h0, OPC_IDX_OUTPUT_MUX_SELECT, 2'b00};
  logic taken;
  logic wr_act;
  logic rd_act;
  logic [31:0] wr_addr;
  logic [3:0] vol_hit;

  assign taken = HSEL && HREADY && (HTRANS == OPC_HTRANS_NONSEQ) && (HSIZE == OPC_HSIZE_WORD);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_act <= 1'b0;
      rd_act <= 1'b0;
      wr_addr <= 32'h0;
    end else if (HREADY) begin
      wr_act <= taken && HWRITE;
      rd_act <= taken && !HWRITE;
      wr_addr <= HADDR;
    end
  end

  // The volume registers sit at consecutive words, channel order matching MUTE.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      vol_hit[i] = wr_act && (wr_addr == {23'h0, OPC_IDX_PHONES_LEFT_VOL + 7'(i), 2'b00});
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_resp_okay: assert property (HRESP == OPC_HRESP_OKAY)
    else $error("response not okay");
  chk_write_zero_wait: assert property (taken && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  chk_read_one_wait: assert property (taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read data phase not one wait state");
  chk_ready_low_cause: assert property ($fell(HREADYOUT) |-> $past(taken) && !$past(HWRITE))
    else $error("ready dropped without a read");
  // Read data is loaded at the edge that ends the wait cycle, so ready was low one cycle earlier.
  chk_rdata_hold: assert property ($changed(HRDATA) |-> $past(rd_act) && !$past(HREADY))
    else $error("read data changed outside a read");
  chk_line_ctrl_write: assert property (LINE_CTRL == (($past(wr_act) && $past(wr_addr) == POP_ADDR) ?
    $past(HWDATA[7:0]) : $past(LINE_CTRL))) else $error("line control output wrong");
  chk_mux_sel_write: assert property (MUX_SEL == (($past(wr_act) && $past(wr_addr) == MUX_ADDR) ?
    $past(HWDATA[3:0]) : $past(MUX_SEL))) else $error("mux select output wrong");
  chk_mute_write: assert property (MUTE == (($past(MUTE) & ~$past(vol_hit)) |
    ({4{$past(HWDATA[8])}} & $past(vol_hit)))) else $error("mute output wrong");

endmodule : opc_output_path_bank_props

bind opc_output_path_bank opc_output_path_bank_props #(.TIMEOUT_TICKS(TIMEOUT_TICKS), .CNT_W(CNT_W)) u_props (
  .CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .TIMEOUT_TICK(TIMEOUT_TICK), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_SIGN(SAMPLE_SIGN),
  .LINE_CTRL(LINE_CTRL), .MUX_SEL(MUX_SEL), .MUTE(MUTE), .GAIN(GAIN));

// file: tb/test_output_path_control_bank.sv
/*
  Self-checking bench for the output path control bank: AHB-Lite register access,
  control outputs, paired volume update, zero-cross gating and timeout.
  Assumes a single slave, so HREADY is HREADYOUT.
*/
`timescale 1ns/100ps

module test_output_path_control_bank;
  import opc_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int unsigned TICKS = 2;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  wire HREADY = HREADYOUT;
  logic TIMEOUT_TICK = 1'b0;
  logic [3:0] SAMPLE_VALID = 4'h0;
  logic [3:0] SAMPLE_SIGN = 4'h0;
  opc_line_ctrl_type LINE_CTRL;
  opc_mux_type MUX_SEL;
  logic [3:0] MUTE;
  opc_gain_vec_type GAIN;
  int bad_count = 0;
  int n_checks = 0;
  logic [31:0] rd_val;

  always #5 CLK = ~CLK;

  opc_output_path_bank #(.TIMEOUT_TICKS(TICKS), .CNT_W(8)) uut (
    .CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .TIMEOUT_TICK(TIMEOUT_TICK), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_SIGN(SAMPLE_SIGN),
    .LINE_CTRL(LINE_CTRL), .MUX_SEL(MUX_SEL), .MUTE(MUTE), .GAIN(GAIN));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  function automatic logic [31:0] ba(input opc_idx_type idx);
    return {23'h0, idx, 2'b00};
  endfunction : ba

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Ready is looked at mid-cycle, so the edge that follows is the one that samples it high.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(negedge CLK);
    while (HREADYOUT !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        close_out();
      end
      @(negedge CLK);
    end
    @(posedge CLK);
    // Read data is taken at the edge that samples ready high, where it still stands.
    rd_val = HRDATA;
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= OPC_HTRANS_NONSEQ;
    HWRITE <= wr;
    HSIZE <= OPC_HSIZE_WORD;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wr ? d : 32'h0;
    wait_rdy();
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd_val, exp);
  endtask : rd_chk

  task automatic sample(input int ch, input logic s);
    SAMPLE_VALID[ch] <= 1'b1;
    SAMPLE_SIGN[ch] <= s;
    @(posedge CLK);
    SAMPLE_VALID[ch] <= 1'b0;
    @(posedge CLK);
  endtask : sample

  task automatic tick_once;
    TIMEOUT_TICK <= 1'b1;
    repeat (4) @(posedge CLK);
    TIMEOUT_TICK <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask : tick_once

  // Ends mid-cycle so that the caller can compare other outputs in the same cycle.
  task automatic wait_gain(input int ch, input opc_gain_type exp);
    int n;
    n = 0;
    @(negedge CLK);
    while (GAIN[ch] !== exp && n < 40) begin
      n++;
      @(negedge CLK);
    end
    check(32'(GAIN[ch]), 32'(exp));
  endtask : wait_gain

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    check(32'(LINE_CTRL), 32'h0);
    check(32'(MUX_SEL), 32'h0);
    check(32'(MUTE), 32'h0);
    check(32'(GAIN), {8'h0, {4{OPC_PHONES_GAIN_RST}}});
    @(posedge CLK);
    rd_chk(ba(OPC_IDX_LINE_OUTPUT_POP_CONTROL), 32'h0);
    rd_chk(ba(OPC_IDX_OUTPUT_MUX_SELECT), 32'h0);
    rd_chk(ba(OPC_IDX_PHONES_LEFT_VOL), 32'h2D);
    rd_chk(ba(OPC_IDX_LINE_RIGHT_VOL), 32'h39);
    rd_chk(32'h100, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(ba(OPC_IDX_LINE_OUTPUT_POP_CONTROL), 32'h1 << i);
      @(negedge CLK);
      check(32'(LINE_CTRL), 32'h1 << i);
      @(posedge CLK);
      rd_chk(ba(OPC_IDX_LINE_OUTPUT_POP_CONTROL), 32'h1 << i);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ba(OPC_IDX_OUTPUT_MUX_SELECT), 32'h1 << i);
      @(negedge CLK);
      check(32'(MUX_SEL), 32'h1 << i);
      @(posedge CLK);
    end
    wr(ba(OPC_IDX_OUTPUT_MUX_SELECT), 32'hF);
    wr(32'h100, 32'h0);
    rd_chk(ba(OPC_IDX_OUTPUT_MUX_SELECT), 32'hF);
    wr(ba(OPC_IDX_LINE_OUTPUT_POP_CONTROL), 32'h10);
    repeat (2000) @(posedge CLK);
    wr(ba(OPC_IDX_LINE_OUTPUT_POP_CONTROL), 32'h30);
    wr(ba(OPC_IDX_LINE_OUTPUT_POP_CONTROL), 32'h70);
    wr(ba(OPC_IDX_LINE_OUTPUT_POP_CONTROL), 32'hF0);
    rd_chk(ba(OPC_IDX_LINE_OUTPUT_POP_CONTROL), 32'hF0);
    wr(ba(OPC_IDX_PHONES_LEFT_VOL), 32'h10);
    repeat (5) @(negedge CLK);
    check(32'(GAIN[0]), 32'h2D);
    @(posedge CLK);
    wr(ba(OPC_IDX_PHONES_RIGHT_VOL), 32'hA0);
    wait_gain(0, 6'h10);
    check(32'(GAIN[1]), 32'h20);
    check(32'(GAIN[2]), 32'h2D);
    @(posedge CLK);
    wr(ba(OPC_IDX_LINE_LEFT_VOL), 32'h139);
    repeat (3) @(negedge CLK);
    check(32'(MUTE), 32'h4);
    check(32'(GAIN[2]), 32'h2D);
    @(posedge CLK);
    rd_chk(ba(OPC_IDX_APPLIED_GAIN), {8'h0, 6'h2D, 6'h2D, 6'h20, 6'h10});
    wr(ba(OPC_IDX_LINE_LEFT_VOL), 32'h145);
    wr(ba(OPC_IDX_LINE_RIGHT_VOL), 32'hC6);
    rd_chk(ba(OPC_IDX_PENDING_STATUS), 32'hC);
    sample(2, 1'b0);
    sample(2, 1'b0);
    repeat (4) @(negedge CLK);
    check(32'(GAIN[2]), 32'h2D);
    @(posedge CLK);
    sample(2, 1'b1);
    wait_gain(2, 6'h05);
    check(32'(GAIN[3]), 32'h2D);
    @(posedge CLK);
    repeat (4) tick_once();
    @(negedge CLK);
    check(32'(GAIN[3]), 32'h2D);
    @(posedge CLK);
    wr(ba(OPC_IDX_TIMEOUT_CONTROL), 32'h1);
    tick_once();
    @(negedge CLK);
    check(32'(GAIN[3]), 32'h2D);
    @(posedge CLK);
    tick_once();
    wait_gain(3, 6'h06);
    check(32'(MUTE), 32'h4);
    close_out();
  end

endmodule : test_output_path_control_bank
